// >>> design/eac_access.sv
// Purpose: cpu-side control of nonvolatile byte reads and programming
// Assumes: array reads combinationally; cpu, irq gate and flash busy share clk_in
// Notes: programming survives rst_in; only por_in aborts it
`timescale 1ns/1ps
module eac_access #(
  parameter int unsigned ATOMIC_CYC = eac_pkg::PROG_ATOMIC_CYC,
  parameter int unsigned SPLIT_CYC = eac_pkg::PROG_SPLIT_CYC
) (
  // clock and resets
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic por_in,
  // cpu register access
  input wire logic cpu_io_in,
  input wire logic [eac_pkg::DS_ADDR_W-1:0] cpu_addr_in,
  input wire logic cpu_wr_in,
  input wire logic cpu_rd_in,
  input wire logic [7:0] cpu_wdata_in,
  input wire logic cpu_bit_set_in,
  input wire logic cpu_bit_clr_in,
  input wire logic cpu_bit_test_in,
  input wire logic [2:0] cpu_bit_idx_in,
  output logic [7:0] cpu_rdata_out,
  output logic cpu_bit_val_out,
  output logic cpu_hit_out,
  output logic cpu_stall_out,
  // interrupt and system status
  input wire logic gie_in,
  input wire logic flash_busy_in,
  output logic ready_irq_out,
  // array side
  output logic [eac_pkg::NV_ADDR_W-1:0] arr_addr_out,
  input wire logic [7:0] arr_rdata_in,
  output logic [7:0] arr_wdata_out,
  output logic arr_erase_out,
  output logic arr_program_out
);
  import eac_pkg::*;

  logic [DS_ADDR_W-1:0] ds_addr;
  logic ok_access;
  logic bit_ok;
  logic bit_op;
  logic sel_ctl;
  logic sel_data;
  logic sel_alo;
  logic sel_ahi;
  logic any_sel;
  logic wr_en;
  logic rd_req;
  logic [7:0] wmask;
  logic [7:0] wval;
  logic [7:0] cur_val;
  logic [8:0] addr_reg;
  logic [7:0] data_reg;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic rie_reg;
  logic [2:0] arm_cnt_reg;
  logic arm_bit;
  logic arm_set;
  logic [2:0] stall_cnt_reg;
  eac_eng_type eng_reg;
  logic busy;
  logic [PROG_CNT_W-1:0] prog_cnt_reg;
  logic [PROG_CNT_W-1:0] prog_load;
  logic [7:0] arr_wdata_reg;
  logic erase_reg;
  logic program_reg;
  logic wr_try;
  logic wr_go;
  logic rd_go;
  logic [7:0] rdata_reg;
  logic bitval_reg;
  logic hit_reg;

  assign busy = (eng_reg == ENG_PROG);
  assign arm_bit = (arm_cnt_reg != 3'h0);

  // address decode and write shaping
  always_comb begin
    // io numbering stops at the io range
    ok_access = !cpu_io_in || (cpu_addr_in <= IO_LAST);
    ds_addr = cpu_io_in ? cpu_addr_in + IO_TO_DS : cpu_addr_in;
    // bit ops only in low io range
    bit_ok = cpu_io_in && (cpu_addr_in <= BIT_IO_LAST);
    bit_op = (cpu_bit_set_in || cpu_bit_clr_in) && bit_ok;
    sel_ctl = ok_access && (ds_addr == DS_CTL);
    sel_data = ok_access && (ds_addr == DS_DATA);
    sel_alo = ok_access && (ds_addr == DS_ADDR_LO);
    sel_ahi = ok_access && (ds_addr == DS_ADDR_HI);
    any_sel = sel_ctl || sel_data || sel_alo || sel_ahi;
    wr_en = (cpu_wr_in && ok_access) || bit_op;
    rd_req = (cpu_rd_in && ok_access) || (cpu_bit_test_in && bit_ok);
    // single-bit ops carry a one-hot mask
    wmask = bit_op ? (8'h01 << cpu_bit_idx_in) : 8'hFF;
    wval = bit_op ? {8{cpu_bit_set_in}} : cpu_wdata_in;
  end

  // read value of the selected register
  always_comb begin
    cur_val = 8'h00;
    if (sel_ctl) begin
      cur_val[CTL_MODE_HI] = mode_reg[1];
      cur_val[CTL_MODE_LO] = mode_reg[0];
      cur_val[CTL_RIE_BIT] = rie_reg;
      cur_val[CTL_ARM_BIT] = arm_bit;
      cur_val[CTL_WR_BIT] = busy;
    end else if (sel_data) begin
      cur_val = data_reg;
    end else if (sel_alo) begin
      cur_val = addr_reg[7:0];
    end else if (sel_ahi) begin
      cur_val[0] = addr_reg[8];
    end
  end

  // control strobes and mode update
  always_comb begin
    mode_next = mode_reg;
    if (wr_en && sel_ctl && !busy) begin
      if (wmask[CTL_MODE_LO]) begin
        mode_next[0] = wval[CTL_MODE_LO];
      end
      if (wmask[CTL_MODE_HI]) begin
        mode_next[1] = wval[CTL_MODE_HI];
      end
    end
    arm_set = wr_en && sel_ctl && wmask[CTL_ARM_BIT] && wval[CTL_ARM_BIT];
    wr_try = wr_en && sel_ctl && wmask[CTL_WR_BIT] && wval[CTL_WR_BIT];
    // strobe counts only inside arm window
    wr_go = wr_try && arm_bit && !busy && !flash_busy_in && (mode_next != MODE_RSVD);
    rd_go = wr_en && sel_ctl && wmask[CTL_RD_BIT] && wval[CTL_RD_BIT] && !busy;
    prog_load = (mode_next == MODE_ATOMIC) ? PROG_CNT_W'(ATOMIC_CYC) : PROG_CNT_W'(SPLIT_CYC);
  end

  // address loaded by software before use
  // bit eight stored as written, drives the top array address bit
  // cpu reset must not retarget a cell write in flight
  always_ff @(posedge clk_in or posedge por_in) begin
    if (por_in) begin
      addr_reg <= ADDR_RST;
    end else if (rst_in && !busy) begin
      addr_reg <= ADDR_RST;
    end else if (wr_en && !busy) begin
      if (sel_alo) begin
        addr_reg[7:0] <= (addr_reg[7:0] & ~wmask) | (wval & wmask);
      end else if (sel_ahi && wmask[0]) begin
        addr_reg[8] <= wval[0];
      end
    end
  end

  // data from array on read, else cpu
  // read lands in data register at once
  always_ff @(posedge clk_in or posedge rst_in or posedge por_in) begin
    if (rst_in || por_in) begin
      data_reg <= DATA_RST;
    end else if (rd_go) begin
      data_reg <= arr_rdata_in;
    end else if (wr_en && sel_data) begin
      data_reg <= (data_reg & ~wmask) | (wval & wmask);
    end
  end

  // cpu reset spares mode during programming
  always_ff @(posedge clk_in or posedge por_in) begin
    if (por_in) begin
      mode_reg <= MODE_RST;
    end else if (rst_in && !busy) begin
      mode_reg <= MODE_RST;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in or posedge por_in) begin
    if (rst_in || por_in) begin
      rie_reg <= 1'b0;
    end else if (wr_en && sel_ctl && wmask[CTL_RIE_BIT]) begin
      rie_reg <= wval[CTL_RIE_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in or posedge por_in) begin
    if (rst_in || por_in) begin
      arm_cnt_reg <= 3'h0;
    end else if (arm_set) begin
      arm_cnt_reg <= ARM_WINDOW_CYC;
    end else if (arm_bit) begin
      arm_cnt_reg <= arm_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in or posedge por_in) begin
    if (rst_in || por_in) begin
      stall_cnt_reg <= 3'h0;
    end else if (rd_go) begin
      stall_cnt_reg <= RD_STALL_CYC;
    end else if (wr_go) begin
      stall_cnt_reg <= WR_STALL_CYC;
    end else if (stall_cnt_reg != 3'h0) begin
      stall_cnt_reg <= stall_cnt_reg - 3'h1;
    end
  end

  // programming engine; only power-on reset may abort a cell write
  always_ff @(posedge clk_in or posedge por_in) begin
    if (por_in) begin
      eng_reg <= ENG_IDLE;
      prog_cnt_reg <= '0;
      erase_reg <= 1'b0;
      program_reg <= 1'b0;
      arr_wdata_reg <= DATA_RST;
    end else begin
      case (eng_reg)
        ENG_IDLE: begin
          if (wr_go) begin
            eng_reg <= ENG_PROG;
            prog_cnt_reg <= prog_load;
            erase_reg <= (mode_next != MODE_WRITE);
            program_reg <= (mode_next != MODE_ERASE);
            arr_wdata_reg <= data_reg;
          end
        end
        ENG_PROG: begin
          // strobe drops when time is up
          if (prog_cnt_reg == PROG_CNT_W'(1)) begin
            eng_reg <= ENG_IDLE;
            erase_reg <= 1'b0;
            program_reg <= 1'b0;
          end
          prog_cnt_reg <= prog_cnt_reg - PROG_CNT_W'(1);
        end
        default: begin
          eng_reg <= ENG_IDLE;
        end
      endcase
    end
  end

  // registered read answer
  always_ff @(posedge clk_in or posedge rst_in or posedge por_in) begin
    if (rst_in || por_in) begin
      rdata_reg <= 8'h00;
      bitval_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= (rd_req || wr_en) && any_sel;
      if (rd_req) begin
        rdata_reg <= cur_val;
      end
      if (cpu_bit_test_in && bit_ok) begin
        bitval_reg <= cur_val[cpu_bit_idx_in];
      end
    end
  end

  assign cpu_rdata_out = rdata_reg;
  assign cpu_bit_val_out = bitval_reg;
  assign cpu_hit_out = hit_reg;
  assign cpu_stall_out = (stall_cnt_reg != 3'h0);
  assign arr_addr_out = addr_reg;
  assign arr_wdata_out = arr_wdata_reg;
  assign arr_erase_out = erase_reg;
  assign arr_program_out = program_reg;
  // gated by enable and global enable
  assign ready_irq_out = rie_reg && gie_in && !busy && !flash_busy_in;

  // checking helpers
  logic [PROG_CNT_W-1:0] busy_len_reg;
  logic [PROG_CNT_W-1:0] busy_exp_reg;
  always_ff @(posedge clk_in or posedge por_in) begin
    if (por_in) begin
      busy_len_reg <= '0;
      busy_exp_reg <= '0;
    end else if (wr_go) begin
      busy_len_reg <= '0;
      busy_exp_reg <= prog_load;
    end else if (busy) begin
      busy_len_reg <= busy_len_reg + PROG_CNT_W'(1);
    end
  end

  default clocking ast_cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in || por_in);

  AST_RSV_ZERO: assert property ((rd_req && (sel_ahi || sel_ctl)) |=>
    (cpu_rdata_out[7:6] == 2'h0) && ($past(sel_ctl) || cpu_rdata_out[7:1] == 7'h00))
    else $error("reserved bits read nonzero");
  AST_ARM_TIMEOUT: assert property (arm_set ##1 !arm_set [*4] |=> !arm_bit)
    else $error("arm bit outlived its window");
  AST_ARM_HOLD: assert property (arm_set |=> arm_bit [*4])
    else $error("arm window shorter than four cycles");
  AST_START_ARMED: assert property ($rose(busy) |-> $past(arm_bit) && $past(wr_try))
    else $error("programming started without arm");
  AST_RSVD_NOP: assert property ((wr_try && !busy && mode_next == MODE_RSVD) |=> !busy)
    else $error("reserved mode started programming");
  AST_MODE_LOCK: assert property (busy |=> $stable(mode_reg))
    else $error("mode changed while programming");
  AST_ADDR_LOCK: assert property (busy |=> $stable(addr_reg))
    else $error("address changed while programming");
  AST_PROG_TIME: assert property ($fell(busy) |-> busy_len_reg == busy_exp_reg)
    else $error("programming time mismatch");
  AST_IRQ_HELD: assert property ((busy || flash_busy_in) |-> !ready_irq_out)
    else $error("ready irq during programming");
  AST_IRQ_GATE: assert property (!(rie_reg && gie_in) |-> !ready_irq_out)
    else $error("ready irq without enables");
  AST_RD_STALL: assert property (rd_go |=> cpu_stall_out [*4] ##1 !cpu_stall_out)
    else $error("read stall not four cycles");
  AST_RD_DATA: assert property (rd_go |=> data_reg == $past(arr_rdata_in))
    else $error("read byte not captured");
  AST_WR_STALL: assert property (wr_go |=> cpu_stall_out [*2] ##1 !cpu_stall_out)
    else $error("write stall not two cycles");
  AST_BIT_ONLY: assert property ((bit_op && sel_ctl && cpu_bit_idx_in != 3'h3) |=> $stable(rie_reg))
    else $error("bit op touched another bit");

  COV_WRITE: cover property (wr_go ##1 busy);
  COV_READ: cover property (rd_go ##1 cpu_stall_out);
  COV_RSVD: cover property (wr_try && arm_bit && mode_next == MODE_RSVD);
  COV_ARM_LAPSE: cover property (arm_set ##1 !arm_set [*4] ##1 wr_try);

endmodule

// >>> design/eac_pkg.sv
// Purpose: shared constants for the nonvolatile byte access control block
// Assumes: 250 MHz cpu clock, registers reached by io or data-space accesses
// Notes: io addresses map into data space at a fixed offset
package eac_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned PROG_ATOMIC_US = 3400;
  localparam int unsigned PROG_SPLIT_US = 1800;
  localparam int unsigned PROG_ATOMIC_CYC = PROG_ATOMIC_US * CLK_MHZ;
  localparam int unsigned PROG_SPLIT_CYC = PROG_SPLIT_US * CLK_MHZ;
  localparam int unsigned PROG_CNT_W = 20;
  localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;
  localparam logic [2:0] RD_STALL_CYC = 3'h4;
  localparam logic [2:0] WR_STALL_CYC = 3'h2;

  // address map, io numbering and data-space numbering
  localparam int unsigned DS_ADDR_W = 12;
  localparam int unsigned NV_ADDR_W = 9;
  localparam logic [11:0] IO_TO_DS = 12'h020;
  localparam logic [11:0] IO_LAST = 12'h03F;
  localparam logic [11:0] BIT_IO_LAST = 12'h01F;
  localparam logic [11:0] IO_CTL = 12'h01F;
  localparam logic [11:0] IO_DATA = 12'h020;
  localparam logic [11:0] IO_ADDR_LO = 12'h021;
  localparam logic [11:0] IO_ADDR_HI = 12'h022;
  localparam logic [11:0] DS_CTL = IO_CTL + IO_TO_DS;
  localparam logic [11:0] DS_DATA = IO_DATA + IO_TO_DS;
  localparam logic [11:0] DS_ADDR_LO = IO_ADDR_LO + IO_TO_DS;
  localparam logic [11:0] DS_ADDR_HI = IO_ADDR_HI + IO_TO_DS;

  // control register fields
  localparam int unsigned CTL_RD_BIT = 0;
  localparam int unsigned CTL_WR_BIT = 1;
  localparam int unsigned CTL_ARM_BIT = 2;
  localparam int unsigned CTL_RIE_BIT = 3;
  localparam int unsigned CTL_MODE_LO = 4;
  localparam int unsigned CTL_MODE_HI = 5;

  // programming action encodings
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  // reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [8:0] ADDR_RST = 9'h000;
  localparam logic [7:0] DATA_RST = 8'h00;

  typedef enum logic {ENG_IDLE, ENG_PROG} eac_eng_type;

endpackage

// >>> dv/eac_access_tb_top.sv
// Purpose: self-checking bench for the nonvolatile byte access control block
// Assumes: short programming counts; cpu side driven by tasks
// Notes: every request waits out cpu_stall_out first
`timescale 1ns/1ps
module eac_access_tb_top;
  import eac_pkg::*;
  localparam int unsigned ATOM = 40;
  localparam int unsigned SPLIT = 24;
  logic clk_in, rst_in, por_in, cpu_io_in, cpu_wr_in, cpu_rd_in, gie_in, flash_busy_in;
  logic cpu_bit_set_in, cpu_bit_clr_in, cpu_bit_test_in, cpu_bit_val_out, cpu_hit_out, cpu_stall_out;
  logic ready_irq_out, arr_erase_out, arr_program_out;
  logic [11:0] cpu_addr_in;
  logic [7:0] cpu_wdata_in, cpu_rdata_out, arr_rdata_in, arr_wdata_out;
  logic [2:0] cpu_bit_idx_in;
  logic [8:0] arr_addr_out;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  eac_access #(.ATOMIC_CYC(ATOM), .SPLIT_CYC(SPLIT)) dut (.clk_in(clk_in), .rst_in(rst_in), .por_in(por_in),
    .cpu_io_in(cpu_io_in), .cpu_addr_in(cpu_addr_in), .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in),
    .cpu_wdata_in(cpu_wdata_in), .cpu_bit_set_in(cpu_bit_set_in), .cpu_bit_clr_in(cpu_bit_clr_in),
    .cpu_bit_test_in(cpu_bit_test_in), .cpu_bit_idx_in(cpu_bit_idx_in), .cpu_rdata_out(cpu_rdata_out),
    .cpu_bit_val_out(cpu_bit_val_out), .cpu_hit_out(cpu_hit_out), .cpu_stall_out(cpu_stall_out),
    .gie_in(gie_in), .flash_busy_in(flash_busy_in), .ready_irq_out(ready_irq_out),
    .arr_addr_out(arr_addr_out), .arr_rdata_in(arr_rdata_in), .arr_wdata_out(arr_wdata_out),
    .arr_erase_out(arr_erase_out), .arr_program_out(arr_program_out));

  eac_array_model model (.clk_in(clk_in), .addr_in(arr_addr_out), .wdata_in(arr_wdata_out),
    .erase_in(arr_erase_out), .program_in(arr_program_out), .rdata_out(arr_rdata_in));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard, well above the planned run
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task req(input logic io, input logic [11:0] a, input logic [7:0] d, input logic [4:0] k, input logic [2:0] b);
    @(posedge clk_in);
    while (cpu_stall_out === 1'b1) @(posedge clk_in);
    cpu_io_in <= io;
    cpu_addr_in <= a;
    cpu_wdata_in <= d;
    cpu_bit_idx_in <= b;
    {cpu_wr_in, cpu_rd_in, cpu_bit_set_in, cpu_bit_clr_in, cpu_bit_test_in} <= k;
    @(posedge clk_in);
    {cpu_wr_in, cpu_rd_in, cpu_bit_set_in, cpu_bit_clr_in, cpu_bit_test_in} <= 5'h00;
  endtask

  task wr(input logic io, input logic [11:0] a, input logic [7:0] d);
    req(io, a, d, 5'h10, 3'h0);
  endtask

  task rdchk(input string name, input logic io, input logic [11:0] a, input logic [7:0] exp);
    req(io, a, 8'h00, 5'h08, 3'h0);
    #1;
    chk(name, exp, cpu_rdata_out);
  endtask

  task wait_idle;
    int n;
    n = 0;
    while ((arr_erase_out | arr_program_out) !== 1'b0 && n < 200) begin
      @(posedge clk_in);
      n++;
    end
    chk("engine idle", 8'h00, {7'h00, arr_erase_out | arr_program_out});
  endtask

  task t_map_read;
    int n;
    rdchk("ctl reset", 0, DS_CTL, 8'h00);
    rdchk("addr hi reset", 1, IO_ADDR_HI, 8'h00);
    chk("hit", 8'h01, {7'h00, cpu_hit_out});
    wr(1, IO_ADDR_LO, 8'h21);
    wr(0, DS_ADDR_HI, 8'h00);
    wr(1, 12'h041, 8'h33);
    #1;
    chk("io hit above range", 8'h00, {7'h00, cpu_hit_out});
    req(1, IO_ADDR_LO, 8'h00, 5'h04, 3'h7);
    rdchk("addr lo mirror", 0, DS_ADDR_LO, 8'h21);
    wr(1, IO_CTL, 8'h01);
    n = 0;
    #1;
    while (cpu_stall_out === 1'b1 && n < 20) begin
      n++;
      @(posedge clk_in);
      #1;
    end
    chk("read stall", 8'h04, n[7:0]);
    rdchk("read byte", 0, DS_DATA, 8'h84);
    rdchk("read strobe bit", 1, IO_CTL, 8'h00);
  endtask

  task t_lapse;
    req(1, IO_CTL, 8'h00, 5'h04, 3'(CTL_ARM_BIT));
    req(1, IO_CTL, 8'h00, 5'h01, 3'(CTL_ARM_BIT));
    #1;
    chk("arm open", 8'h01, {7'h00, cpu_bit_val_out});
    repeat (5) @(posedge clk_in);
    req(1, IO_CTL, 8'h00, 5'h01, 3'(CTL_ARM_BIT));
    #1;
    chk("arm lapsed", 8'h00, {7'h00, cpu_bit_val_out});
    req(1, IO_CTL, 8'h00, 5'h04, 3'(CTL_WR_BIT));
    #1;
    chk("late strobe", 8'h00, {6'h00, arr_erase_out, arr_program_out});
  endtask

  task t_prog(input logic [1:0] m, input int len, input logic e, input logic p, input logic [7:0] expm);
    int n;
    wr(1, IO_ADDR_LO, 8'h10);
    wr(1, IO_DATA, 8'h3C);
    wr(1, IO_CTL, {2'h0, m, 4'h8});
    req(1, IO_CTL, 8'h00, 5'h04, 3'(CTL_ARM_BIT));
    req(1, IO_CTL, 8'h00, 5'h04, 3'(CTL_WR_BIT));
    #1;
    chk("action lines", {6'h00, e, p}, {6'h00, arr_erase_out, arr_program_out});
    n = 0;
    while ((arr_erase_out | arr_program_out) === 1'b1 && n < 200) begin
      n++;
      @(posedge clk_in);
      #1;
    end
    chk("program time", len[7:0], n[7:0]);
    chk("ready irq", 8'h01, {7'h00, ready_irq_out});
    // no stall after a refused start, so let the arm window lapse
    repeat (4) @(posedge clk_in);
    rdchk("ctl after", 1, IO_CTL, {2'h0, m, 4'h8});
    wr(1, IO_CTL, 8'h09);
    rdchk("cell", 1, IO_DATA, expm);
  endtask

  task t_refuse;
    wr(1, IO_DATA, 8'hC3);
    wr(1, IO_CTL, 8'h08);
    req(1, IO_CTL, 8'h00, 5'h04, 3'(CTL_ARM_BIT));
    req(1, IO_CTL, 8'h00, 5'h04, 3'(CTL_WR_BIT));
    wr(1, IO_ADDR_LO, 8'h77);
    wr(1, IO_CTL, 8'h18);
    wr(1, IO_CTL, 8'h09);
    #1;
    chk("irq while busy", 8'h00, {7'h00, ready_irq_out});
    rdchk("mode held", 1, IO_CTL, 8'h0A);
    rdchk("addr held", 1, IO_ADDR_LO, 8'h10);
    wait_idle;
    rdchk("no busy read", 1, IO_DATA, 8'hC3);
    @(posedge clk_in);
    gie_in <= 1'b0;
    #1;
    chk("irq gated", 8'h00, {7'h00, ready_irq_out});
    @(posedge clk_in);
    gie_in <= 1'b1;
    flash_busy_in <= 1'b1;
    #1;
    chk("irq flash busy", 8'h00, {7'h00, ready_irq_out});
    @(posedge clk_in);
    flash_busy_in <= 1'b0;
    req(1, IO_CTL, 8'h00, 5'h02, 3'(CTL_RIE_BIT));
    #1;
    chk("irq disabled", 8'h00, {7'h00, ready_irq_out});
  endtask

  task t_rst;
    wr(1, IO_CTL, 8'h20);
    req(1, IO_CTL, 8'h00, 5'h04, 3'(CTL_ARM_BIT));
    req(1, IO_CTL, 8'h00, 5'h04, 3'(CTL_WR_BIT));
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    rdchk("mode kept busy", 1, IO_CTL, 8'h22);
    wait_idle;
    @(posedge clk_in);
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    rdchk("mode cleared", 1, IO_CTL, 8'h00);
    // reset mid-write must not move the write to address zero
    wr(1, IO_CTL, 8'h01);
    rdchk("cell kept", 1, IO_DATA, 8'hA5);
  endtask

  initial begin
    {cpu_io_in, cpu_wr_in, cpu_rd_in, flash_busy_in} = 4'h0;
    {cpu_bit_set_in, cpu_bit_clr_in, cpu_bit_test_in} = 3'h0;
    {rst_in, por_in, gie_in} = 3'h7;
    cpu_addr_in = 12'h000;
    cpu_wdata_in = 8'h00;
    cpu_bit_idx_in = 3'h0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    por_in <= 1'b0;
    t_map_read;
    t_lapse;
    t_prog(MODE_ATOMIC, ATOM, 1'b1, 1'b1, 8'h3C);
    t_prog(MODE_ERASE, SPLIT, 1'b1, 1'b0, 8'hFF);
    t_prog(MODE_WRITE, SPLIT, 1'b0, 1'b1, 8'h3C);
    t_prog(MODE_RSVD, 0, 1'b0, 1'b0, 8'h3C);
    t_refuse;
    t_rst;
    tally_and_finish;
  end
endmodule

// >>> dv/eac_array_model.sv
// Purpose: behavioural byte array seen through the block's array port
// Assumes: one clock; an operation runs while erase or program is high
// Notes: cells change only when the operation ends, so a bad early read shows
`timescale 1ns/1ps
module eac_array_model (
  // array control from the block
  input wire logic clk_in,
  input wire logic [8:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic erase_in,
  input wire logic program_in,
  // read path
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:511];
  logic [8:0] op_addr_reg;
  logic op_erase_reg;
  logic op_program_reg;
  logic busy_reg;

  initial begin
    busy_reg = 1'b0;
    for (int i = 0; i < 512; i++) begin
      mem[i] = i[7:0] ^ 8'hA5;
    end
  end

  assign rdata_out = mem[addr_in];

  // apply erase, write or both at the end
  always @(posedge clk_in) begin
    if ((erase_in || program_in) && !busy_reg) begin
      busy_reg <= 1'b1;
      op_addr_reg <= addr_in;
      op_erase_reg <= erase_in;
      op_program_reg <= program_in;
    end else if (busy_reg && !erase_in && !program_in) begin
      busy_reg <= 1'b0;
      if (op_erase_reg && op_program_reg) begin
        mem[op_addr_reg] <= wdata_in;
      end else if (op_erase_reg) begin
        mem[op_addr_reg] <= 8'hFF;
      end else begin
        // write-only can just clear bits, as a real cell would
        mem[op_addr_reg] <= mem[op_addr_reg] & wdata_in;
      end
    end
  end
endmodule
